// >>> verilog/flp_lock_protect.sv
// Top of the flash lock protection block: reset latch, software registers, gating.
`timescale 1ns/1ps
module flp_lock_protect (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [2:0] lock_bits_in,
  input wire logic boot_jump_fuse_in,
  input wire logic external_access_pin_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [1:0] reg_src_in,
  input wire logic erase_defaults_in,
  input wire logic boot_prog_req_in,
  input wire logic boot_verify_req_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_ack_out,
  output logic [1:0] hw_level_out,
  output logic [1:0] sw_level_out,
  output logic table_read_block_out,
  output logic par_prog_block_out,
  output logic par_verify_block_out,
  output logic ext_exec_block_out,
  output logic external_access_latched_out,
  output logic boot_prog_grant_out,
  output logic boot_verify_grant_out,
  output logic boot_refused_out,
  output logic [15:0] boot_entry_out,
  output logic boot_entry_valid_out
);
  import flp_pkg::*;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  // Lock bits, fuse and access pin come from outside the clock domain.
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  logic [4:0] sync1_next;
  logic [4:0] sync2_next;

  always_comb begin
    sync1_next = {external_access_pin_in, boot_jump_fuse_in, lock_bits_in};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sync1_reg <= 5'h1F;
      sync2_reg <= 5'h1F;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  // ---------------------------------------------------------------------
  // Reset-time latch
  // ---------------------------------------------------------------------
  // The capture waits until the synchroniser has refilled after release,
  // so a latch is taken from real pin levels, never from reset filler.
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic captured_reg;
  logic captured_next;
  logic [2:0] hw_lock_reg;
  logic [2:0] hw_lock_next;
  logic jump_fuse_reg;
  logic jump_fuse_next;
  logic ea_pin_reg;
  logic ea_pin_next;

  always_comb begin
    settle_next = settle_reg;
    captured_next = captured_reg;
    hw_lock_next = hw_lock_reg;
    jump_fuse_next = jump_fuse_reg;
    ea_pin_next = ea_pin_reg;
    if (settle_reg != FLP_SETTLE_LAST) begin
      settle_next = settle_reg + 2'h1;
    end else if (!captured_reg) begin
      captured_next = 1'b1;
      hw_lock_next = sync2_reg[2:0];
      jump_fuse_next = sync2_reg[3];
      ea_pin_next = sync2_reg[4];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      settle_reg <= 2'h0;
      captured_reg <= 1'b0;
      hw_lock_reg <= 3'h0;
      jump_fuse_reg <= 1'b0;
      ea_pin_reg <= 1'b0;
    end else begin
      settle_reg <= settle_next;
      captured_reg <= captured_next;
      hw_lock_reg <= hw_lock_next;
      jump_fuse_reg <= jump_fuse_next;
      ea_pin_reg <= ea_pin_next;
    end
  end

  // ---------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------
  logic [7:0] boot_vector_reg;
  logic [7:0] boot_vector_next;
  logic [7:0] boot_status_reg;
  logic [7:0] boot_status_next;
  logic [1:0] sw_lock_reg;
  logic [1:0] sw_lock_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic ack_reg;
  logic ack_next;
  logic [7:0] hw_shadow;

  flp_decode_if dec_bus ();

  assign dec_bus.hw_lock = hw_lock_reg;
  assign dec_bus.sw_lock = sw_lock_reg;

  flp_level_decode u_decode (
    .dec(dec_bus)
  );

  always_comb begin
    hw_shadow = 8'hFF;
    hw_shadow[2:0] = hw_lock_reg;
    hw_shadow[FLP_SHADOW_JUMP_POS] = jump_fuse_reg;
  end

  always_comb begin
    boot_vector_next = boot_vector_reg;
    boot_status_next = boot_status_reg;
    sw_lock_next = sw_lock_reg;
    rdata_next = rdata_reg;
    // A refused write is still acknowledged, so a locked host never stalls.
    ack_next = reg_wr_in || reg_rd_in;
    // Erase outranks a write in the same cycle, so the defaults always land.
    if (erase_defaults_in) begin
      boot_vector_next = FLP_BOOT_VECTOR_RESET;
      boot_status_next = FLP_BOOT_STATUS_RESET;
      sw_lock_next = FLP_SW_PROTECT_RESET[1:0];
    end else if (reg_wr_in) begin
      case (reg_sel_in)
        FLP_SEL_BOOT_VECTOR: begin
          if (!dec_bus.boot_prog_block) begin
            boot_vector_next = reg_wdata_in;
          end
        end
        FLP_SEL_BOOT_STATUS: begin
          if (!dec_bus.boot_prog_block) begin
            boot_status_next = reg_wdata_in;
          end
        end
        FLP_SEL_SW_PROTECT: begin
          // A write only tightens protection; a cleared bit returns to one only on erase or reset.
          sw_lock_next = sw_lock_reg & reg_wdata_in[1:0];
        end
        default: begin
          sw_lock_next = sw_lock_reg;
        end
      endcase
    end
    if (reg_rd_in) begin
      case (reg_sel_in)
        FLP_SEL_BOOT_VECTOR: rdata_next = boot_vector_reg;
        FLP_SEL_BOOT_STATUS: rdata_next = boot_status_reg;
        FLP_SEL_SW_PROTECT: rdata_next = {FLP_SW_PROTECT_RSVD, sw_lock_reg};
        FLP_SEL_HW_SHADOW: rdata_next = hw_shadow;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      boot_vector_reg <= FLP_BOOT_VECTOR_RESET;
      boot_status_reg <= FLP_BOOT_STATUS_RESET;
      sw_lock_reg <= FLP_SW_PROTECT_RESET[1:0];
      rdata_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      boot_vector_reg <= boot_vector_next;
      boot_status_reg <= boot_status_next;
      sw_lock_reg <= sw_lock_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
    end
  end

  // ---------------------------------------------------------------------
  // Output gating and boot entry
  // ---------------------------------------------------------------------
  logic [8:0] out_reg;
  logic [8:0] out_next;
  logic [15:0] entry_reg;
  logic [15:0] entry_next;
  logic entry_valid_reg;
  logic entry_valid_next;

  always_comb begin
    out_next = '0;
    if (captured_reg) begin
      out_next[1:0] = dec_bus.hw_level;
      out_next[3:2] = dec_bus.sw_level;
      out_next[4] = dec_bus.table_read_block;
      out_next[5] = dec_bus.par_prog_block;
      out_next[6] = dec_bus.par_verify_block;
      out_next[7] = dec_bus.ext_exec_block;
      out_next[8] = dec_bus.ea_latch ? ea_pin_reg : sync2_reg[4];
    end
    entry_valid_next = captured_reg;
    entry_next = FLP_BOOT_ENTRY;
    if (jump_fuse_reg && boot_status_reg == FLP_BOOT_STATUS_CLEARED) begin
      entry_next = FLP_APP_ENTRY;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_reg <= '0;
      entry_reg <= FLP_BOOT_ENTRY;
      entry_valid_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      entry_reg <= entry_next;
      entry_valid_reg <= entry_valid_next;
    end
  end

  // ---------------------------------------------------------------------
  // Bootloader request answers
  // ---------------------------------------------------------------------
  // Before the capture every answer stays low, so an early request sees
  // neither a grant nor a refusal that the real lock level might contradict.
  logic [2:0] answer_reg;
  logic [2:0] answer_next;

  always_comb begin
    answer_next = 3'h0;
    if (captured_reg) begin
      answer_next[0] = boot_prog_req_in && !dec_bus.boot_prog_block;
      answer_next[1] = boot_verify_req_in && !dec_bus.boot_verify_block;
      answer_next[2] = (boot_prog_req_in && dec_bus.boot_prog_block) ||
                       (boot_verify_req_in && dec_bus.boot_verify_block);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      answer_reg <= 3'h0;
    end else begin
      answer_reg <= answer_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign reg_ack_out = ack_reg;
  assign hw_level_out = out_reg[1:0];
  assign sw_level_out = out_reg[3:2];
  assign table_read_block_out = out_reg[4];
  assign par_prog_block_out = out_reg[5];
  assign par_verify_block_out = out_reg[6];
  assign ext_exec_block_out = out_reg[7];
  assign external_access_latched_out = out_reg[8];
  assign boot_prog_grant_out = answer_reg[0];
  assign boot_verify_grant_out = answer_reg[1];
  assign boot_refused_out = answer_reg[2];
  assign boot_entry_out = entry_reg;
  assign boot_entry_valid_out = entry_valid_reg;

endmodule

// >>> verilog/flp_pkg.sv
// Package of constants and types shared by the flash lock protection block.
package flp_pkg;

  // ---------------------------------------------------------------------
  // Protection levels
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    FLP_LEVEL_ONE,
    FLP_LEVEL_TWO,
    FLP_LEVEL_THREE,
    FLP_LEVEL_FOUR
  } flp_level_type;

  // ---------------------------------------------------------------------
  // Software register selectors and defaults
  // ---------------------------------------------------------------------
  localparam logic [1:0] FLP_SEL_BOOT_VECTOR = 2'h0;
  localparam logic [1:0] FLP_SEL_BOOT_STATUS = 2'h1;
  localparam logic [1:0] FLP_SEL_SW_PROTECT = 2'h2;
  localparam logic [1:0] FLP_SEL_HW_SHADOW = 2'h3;

  localparam logic [7:0] FLP_BOOT_VECTOR_RESET = 8'hFC;
  localparam logic [7:0] FLP_BOOT_STATUS_RESET = 8'hFF;
  localparam logic [7:0] FLP_SW_PROTECT_RESET = 8'hFF;
  localparam logic [7:0] FLP_BOOT_STATUS_CLEARED = 8'h00;
  localparam logic [5:0] FLP_SW_PROTECT_RSVD = 6'h3F;
  localparam logic [1:0] FLP_SETTLE_LAST = 2'h3;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int FLP_SW_LOCK0_POS = 0;
  localparam int FLP_SW_LOCK1_POS = 1;
  localparam int FLP_SHADOW_JUMP_POS = 6;

  // ---------------------------------------------------------------------
  // Entry addresses
  // ---------------------------------------------------------------------
  localparam logic [15:0] FLP_APP_ENTRY = 16'h0000;
  localparam logic [15:0] FLP_BOOT_ENTRY = 16'hF800;

endpackage

// >>> verilog/flp_decode_if.sv
// Interface carrying lock bits into the decoder and the permissions out of it.
`timescale 1ns/1ps
interface flp_decode_if;
  logic [2:0] hw_lock;
  logic [1:0] sw_lock;
  logic [1:0] hw_level;
  logic [1:0] sw_level;
  logic table_read_block;
  logic par_prog_block;
  logic par_verify_block;
  logic ext_exec_block;
  logic ea_latch;
  logic boot_prog_block;
  logic boot_verify_block;

  modport decoder (
    input hw_lock,
    input sw_lock,
    output hw_level,
    output sw_level,
    output table_read_block,
    output par_prog_block,
    output par_verify_block,
    output ext_exec_block,
    output ea_latch,
    output boot_prog_block,
    output boot_verify_block
  );

  modport user (
    output hw_lock,
    output sw_lock,
    input hw_level,
    input sw_level,
    input table_read_block,
    input par_prog_block,
    input par_verify_block,
    input ext_exec_block,
    input ea_latch,
    input boot_prog_block,
    input boot_verify_block
  );
endinterface

// >>> verilog/flp_level_decode.sv
// Combinational decode of hardware and software lock bits into permissions.
`timescale 1ns/1ps
module flp_level_decode (
  flp_decode_if.decoder dec
);
  import flp_pkg::*;

  always_comb begin
    dec.hw_level = 2'(FLP_LEVEL_ONE);
    if (!dec.hw_lock[2]) begin
      dec.hw_level = 2'(FLP_LEVEL_FOUR);
    end else if (!dec.hw_lock[1]) begin
      dec.hw_level = 2'(FLP_LEVEL_THREE);
    end else if (!dec.hw_lock[0]) begin
      dec.hw_level = 2'(FLP_LEVEL_TWO);
    end
    dec.sw_level = 2'(FLP_LEVEL_ONE);
    if (!dec.sw_lock[1]) begin
      dec.sw_level = 2'(FLP_LEVEL_THREE);
    end else if (!dec.sw_lock[0]) begin
      dec.sw_level = 2'(FLP_LEVEL_TWO);
    end
  end

  assign dec.table_read_block = (dec.hw_level != 2'(FLP_LEVEL_ONE));
  assign dec.par_prog_block = (dec.hw_level != 2'(FLP_LEVEL_ONE));
  assign dec.ea_latch = (dec.hw_level != 2'(FLP_LEVEL_ONE));
  assign dec.par_verify_block = (dec.hw_level == 2'(FLP_LEVEL_THREE)) ||
                                (dec.hw_level == 2'(FLP_LEVEL_FOUR));
  assign dec.ext_exec_block = (dec.hw_level == 2'(FLP_LEVEL_FOUR));
  assign dec.boot_prog_block = (dec.sw_level != 2'(FLP_LEVEL_ONE));
  assign dec.boot_verify_block = (dec.sw_level == 2'(FLP_LEVEL_THREE));
endmodule

// >>> verif/flp_lock_protect_properties.sv
// Concurrent checks on the ports of the flash lock protection block.
`timescale 1ns/1ps
module flp_lock_protect_properties
  import flp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic erase_defaults_in,
  input wire logic boot_prog_req_in,
  input wire logic boot_verify_req_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_ack_out,
  input wire logic [1:0] hw_level_out,
  input wire logic [1:0] sw_level_out,
  input wire logic table_read_block_out,
  input wire logic par_prog_block_out,
  input wire logic par_verify_block_out,
  input wire logic ext_exec_block_out,
  input wire logic boot_prog_grant_out,
  input wire logic boot_verify_grant_out,
  input wire logic boot_refused_out,
  input wire logic boot_entry_valid_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ---------------------------------------------------------------------
  // Hardware level gating
  // ---------------------------------------------------------------------
  property p_free;
    boot_entry_valid_out && $past(boot_entry_valid_out) && hw_level_out == 2'h0 |->
      !(table_read_block_out || par_prog_block_out || par_verify_block_out);
  endproperty
  a_free: assert property (p_free) else $error("level one blocks something");
  property p_two;
    boot_entry_valid_out && $past(boot_entry_valid_out) |->
      table_read_block_out == (hw_level_out != 2'h0) && par_prog_block_out == table_read_block_out;
  endproperty
  a_two: assert property (p_two) else $error("table read or program gate wrong");
  property p_three;
    boot_entry_valid_out && $past(boot_entry_valid_out) |->
      par_verify_block_out == (hw_level_out >= 2'h2);
  endproperty
  a_three: assert property (p_three) else $error("parallel verify gate wrong");
  property p_four;
    boot_entry_valid_out && $past(boot_entry_valid_out) |->
      ext_exec_block_out == (hw_level_out == 2'h3);
  endproperty
  a_four: assert property (p_four) else $error("external execution gate wrong");
  property p_hold;
    boot_entry_valid_out && $past(boot_entry_valid_out) |-> $stable(hw_level_out);
  endproperty
  a_hold: assert property (p_hold) else $error("hardware level moved");
  // ---------------------------------------------------------------------
  // Register access and bootloader requests
  // ---------------------------------------------------------------------
  property p_ack;
    reg_rd_in || reg_wr_in |=> reg_ack_out ##1 !reg_ack_out || $past(reg_rd_in || reg_wr_in);
  endproperty
  a_ack: assert property (p_ack) else $error("register ack not one cycle");
  property p_erase;
    erase_defaults_in ##1 (reg_rd_in && !reg_wr_in && reg_sel_in == FLP_SEL_SW_PROTECT) |=>
      reg_rdata_out == FLP_SW_PROTECT_RESET;
  endproperty
  a_erase: assert property (p_erase) else $error("erase default not read back");
  property p_open;
    boot_entry_valid_out && boot_prog_req_in && boot_verify_req_in && sw_level_out == 2'h0 &&
      !reg_wr_in && !$past(reg_wr_in) |=> boot_prog_grant_out && boot_verify_grant_out;
  endproperty
  a_open: assert property (p_open) else $error("open level refused a request");
  property p_noprog;
    boot_entry_valid_out && boot_prog_req_in && sw_level_out != 2'h0 &&
      !$past(erase_defaults_in) |=> boot_refused_out && !boot_prog_grant_out;
  endproperty
  a_noprog: assert property (p_noprog) else $error("program granted while locked");
  property p_noverify;
    boot_entry_valid_out && boot_verify_req_in && sw_level_out == 2'h2 &&
      !$past(erase_defaults_in) |=> boot_refused_out && !boot_verify_grant_out;
  endproperty
  a_noverify: assert property (p_noverify) else $error("verify granted while locked");
endmodule
bind flp_lock_protect flp_lock_protect_properties i_flp_lock_protect_properties (.clk_in,
  .rst_in, .reg_sel_in, .reg_wr_in, .reg_rd_in, .erase_defaults_in, .boot_prog_req_in,
  .boot_verify_req_in, .reg_rdata_out, .reg_ack_out, .hw_level_out, .sw_level_out,
  .table_read_block_out, .par_prog_block_out, .par_verify_block_out, .ext_exec_block_out,
  .boot_prog_grant_out, .boot_verify_grant_out, .boot_refused_out, .boot_entry_valid_out);

// >>> verif/flp_host_model.sv
// Programming host model that drives the software register port.
`timescale 1ns/1ps
module flp_host_model
  import flp_pkg::*;
(
  input wire logic clk_in,
  input wire logic reg_ack_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [1:0] reg_sel_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_sel_out = 2'h0;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // The strobe is a one-cycle pulse; ack and data are taken one edge later.
  task automatic access(input logic wr, input logic [1:0] sel, input logic [7:0] data,
                        output logic ack, output logic [7:0] rdata);
    @(posedge clk_in);
    reg_sel_out <= sel;
    reg_wdata_out <= (sel == FLP_SEL_SW_PROTECT) ? {FLP_SW_PROTECT_RSVD, data[1:0]} : data;
    reg_wr_out <= wr;
    reg_rd_out <= !wr;
    @(posedge clk_in);
    reg_wr_out <= 1'b0;
    reg_rd_out <= 1'b0;
    // Scrambled data keeps a stale byte from looking like a fresh answer.
    reg_wdata_out <= ~data;
    @(posedge clk_in);
    ack = reg_ack_in;
    rdata = reg_rdata_in;
  endtask
endmodule

// >>> verif/testbench.sv
// Self-checking testbench of the flash lock protection block.
`timescale 1ns/1ps
module testbench;
  import flp_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, fuse = 1'b1, ea = 1'b1, erase = 1'b0;
  logic preq = 1'b0, vreq = 1'b0, ack, ack_r, rd_pulse, wr_pulse;
  logic [2:0] lock = 3'h7;
  logic [1:0] sel, hw_lvl, sw_lvl;
  logic [7:0] rdata, wdata, rd_r;
  logic trb, ppb, pvb, eeb, eal, pg, vg, refd, valid;
  logic [15:0] entry;
  int fails = 0, check_count = 0;
  initial forever #4 clk_in = ~clk_in;
  flp_lock_protect i_flp_lock_protect (.clk_in(clk_in), .rst_in(rst_in),
    .lock_bits_in(lock), .boot_jump_fuse_in(fuse), .external_access_pin_in(ea),
    .reg_sel_in(sel), .reg_wr_in(wr_pulse), .reg_rd_in(rd_pulse), .reg_wdata_in(wdata),
    .reg_src_in(2'h2), .erase_defaults_in(erase), .boot_prog_req_in(preq),
    .boot_verify_req_in(vreq), .reg_rdata_out(rdata), .reg_ack_out(ack),
    .hw_level_out(hw_lvl), .sw_level_out(sw_lvl), .table_read_block_out(trb),
    .par_prog_block_out(ppb), .par_verify_block_out(pvb), .ext_exec_block_out(eeb),
    .external_access_latched_out(eal), .boot_prog_grant_out(pg),
    .boot_verify_grant_out(vg), .boot_refused_out(refd), .boot_entry_out(entry),
    .boot_entry_valid_out(valid));
  flp_host_model i_flp_host_model (.clk_in(clk_in), .reg_ack_in(ack), .reg_rdata_in(rdata),
    .reg_sel_out(sel), .reg_wr_out(wr_pulse), .reg_rd_out(rd_pulse), .reg_wdata_out(wdata));
  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Settle and capture take five edges after release; ten leaves margin.
  task automatic restart(input logic [2:0] lk, input logic fz);
    @(posedge clk_in);
    lock <= lk;
    fuse <= fz;
    ea <= 1'b1;
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (10) @(posedge clk_in);
  endtask
  task automatic rd(input logic [1:0] s, input logic [7:0] exp);
    i_flp_host_model.access(1'b0, s, 8'h00, ack_r, rd_r);
    chk({15'h0, ack_r}, 16'h1);
    chk({8'h0, rd_r}, {8'h0, exp});
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    i_flp_host_model.access(1'b1, s, d, ack_r, rd_r);
    chk({15'h0, ack_r}, 16'h1);
  endtask
  task automatic breq(input logic p, input logic v, input logic [2:0] exp);
    @(posedge clk_in);
    preq <= p;
    vreq <= v;
    repeat (2) @(posedge clk_in);
    chk({13'h0, pg, vg, refd}, {13'h0, exp});
    preq <= 1'b0;
    vreq <= 1'b0;
  endtask
  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_levels();
    logic [1:0] lv;
    for (int i = 0; i < 8; i++) begin
      restart(i[2:0], 1'b1);
      lv = !i[2] ? 2'h3 : !i[1] ? 2'h2 : !i[0] ? 2'h1 : 2'h0;
      ea <= 1'b0;
      lock <= ~i[2:0];
      repeat (6) @(posedge clk_in);
      chk({14'h0, hw_lvl}, {14'h0, lv});
      chk({15'h0, valid}, 16'h1);
      chk({12'h0, trb, ppb, pvb, eeb}, {12'h0, lv != 0, lv != 0, lv >= 2, lv == 3});
      chk({15'h0, eal}, {15'h0, lv != 0});
    end
  endtask
  task automatic t_registers();
    restart(3'h7, 1'b1);
    // contents read back before a lock level is set
    rd(FLP_SEL_BOOT_VECTOR, FLP_BOOT_VECTOR_RESET);
    rd(FLP_SEL_BOOT_STATUS, FLP_BOOT_STATUS_RESET);
    rd(FLP_SEL_SW_PROTECT, FLP_SW_PROTECT_RESET);
    restart(3'h5, 1'b1);
    wr(FLP_SEL_HW_SHADOW, 8'h00);
    rd(FLP_SEL_HW_SHADOW, 8'hFD);
    chk(entry, FLP_BOOT_ENTRY);
    wr(FLP_SEL_BOOT_STATUS, FLP_BOOT_STATUS_CLEARED);
    // The entry register follows the status write one edge later.
    @(posedge clk_in);
    chk(entry, FLP_APP_ENTRY);
    restart(3'h7, 1'b0);
    wr(FLP_SEL_BOOT_STATUS, FLP_BOOT_STATUS_CLEARED);
    @(posedge clk_in);
    chk(entry, FLP_BOOT_ENTRY);
  endtask
  task automatic t_software();
    restart(3'h7, 1'b1);
    breq(1'b1, 1'b1, 3'b110);
    wr(FLP_SEL_SW_PROTECT, 8'h02);
    breq(1'b1, 1'b1, 3'b011);
    chk({14'h0, sw_lvl}, 16'h1);
    wr(FLP_SEL_BOOT_STATUS, 8'h00);
    rd(FLP_SEL_BOOT_STATUS, FLP_BOOT_STATUS_RESET);
    wr(FLP_SEL_SW_PROTECT, 8'h01);
    breq(1'b0, 1'b1, 3'b001);
    chk({14'h0, sw_lvl}, 16'h2);
    rd(FLP_SEL_SW_PROTECT, 8'hFC);
    // The read strobe follows the erase pulse by exactly one cycle.
    fork
      begin
        erase <= 1'b1;
        @(posedge clk_in);
        erase <= 1'b0;
      end
      rd(FLP_SEL_SW_PROTECT, FLP_SW_PROTECT_RESET);
    join
  endtask
  initial begin
    t_levels();
    t_registers();
    t_software();
    final_report();
  end
  // The run needs about 250 cycles; five thousand means a hang.
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    final_report();
  end
endmodule
